// ===== hw/cbfls_pkg.sv
// Constants for the bit, flag and load/store execution block
package cbfls_pkg;
   localparam int ADDR_W = 5;
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_OPND = 5'h04;
   localparam logic [4:0] REG_FLAGS = 5'h08;
   localparam logic [4:0] REG_INFO = 5'h0C;
   localparam logic [4:0] REG_RSEL = 5'h10;
   localparam logic [4:0] REG_RDATA = 5'h14;
   localparam logic [4:0] REG_MADDR = 5'h18;
   localparam logic [4:0] REG_MDATA = 5'h1C;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_RD_LSB = 8;
   localparam int CMD_RR_LSB = 16;
   localparam int CMD_BIT_LSB = 24;
   localparam int CMD_PTR_LSB = 27;
   localparam int CMD_MODE_LSB = 29;
   localparam int DISP_W = 6;
   localparam int RF_WORDS = 32;
   localparam logic [2:0] FLG_C = 3'h0;
   localparam logic [2:0] FLG_Z = 3'h1;
   localparam logic [2:0] FLG_N = 3'h2;
   localparam logic [2:0] FLG_V = 3'h3;
   localparam logic [2:0] FLG_S = 3'h4;
   localparam logic [2:0] FLG_H = 3'h5;
   localparam logic [2:0] FLG_T = 3'h6;
   localparam logic [2:0] FLG_I = 3'h7;
   localparam logic [5:0] OP_ROL = 6'h01;
   localparam logic [5:0] OP_ROR = 6'h02;
   localparam logic [5:0] OP_ASR = 6'h03;
   localparam logic [5:0] OP_SWAP = 6'h04;
   localparam logic [5:0] OP_FSET = 6'h05;
   localparam logic [5:0] OP_FCLR = 6'h06;
   localparam logic [5:0] OP_BST = 6'h07;
   localparam logic [5:0] OP_BLD = 6'h08;
   localparam logic [5:0] OP_MOV = 6'h09;
   localparam logic [5:0] OP_REG_PAIR_COPY = 6'h0A;
   localparam logic [5:0] OP_LDI = 6'h0B;
   localparam logic [5:0] OP_LD = 6'h0C;
   localparam logic [5:0] OP_LDD = 6'h0D;
   localparam logic [5:0] OP_LDS = 6'h0E;
   localparam logic [5:0] OP_ST = 6'h0F;
   localparam logic [1:0] OP_FLAG_GRP = 2'h1;
   localparam logic [5:0] OP_CARRY_FLAG_RAISE = {OP_FLAG_GRP, 1'b1, FLG_C};
   localparam logic [5:0] OP_CARRY_FLAG_DROP = {OP_FLAG_GRP, 1'b0, FLG_C};
   localparam logic [5:0] OP_NEGATIVE_FLAG_RAISE = {OP_FLAG_GRP, 1'b1, FLG_N};
   localparam logic [5:0] OP_NEGATIVE_FLAG_DROP = {OP_FLAG_GRP, 1'b0, FLG_N};
   localparam logic [5:0] OP_ZERO_FLAG_RAISE = {OP_FLAG_GRP, 1'b1, FLG_Z};
   localparam logic [5:0] OP_ZERO_FLAG_DROP = {OP_FLAG_GRP, 1'b0, FLG_Z};
   localparam logic [5:0] OP_IRQ_GLOBAL_ON = {OP_FLAG_GRP, 1'b1, FLG_I};
   localparam logic [5:0] OP_IRQ_GLOBAL_OFF = {OP_FLAG_GRP, 1'b0, FLG_I};
   localparam logic [5:0] OP_SIGN_FLAG_RAISE = {OP_FLAG_GRP, 1'b1, FLG_S};
   localparam logic [5:0] OP_SIGN_FLAG_DROP = {OP_FLAG_GRP, 1'b0, FLG_S};
   localparam logic [5:0] OP_OVERFLOW_FLAG_RAISE = {OP_FLAG_GRP, 1'b1, FLG_V};
   localparam logic [5:0] OP_OVERFLOW_FLAG_DROP = {OP_FLAG_GRP, 1'b0, FLG_V};
   localparam logic [5:0] OP_TRANSFER_FLAG_RAISE = {OP_FLAG_GRP, 1'b1, FLG_T};
   localparam logic [5:0] OP_TRANSFER_FLAG_DROP = {OP_FLAG_GRP, 1'b0, FLG_T};
   localparam logic [5:0] OP_HALF_CARRY_RAISE = {OP_FLAG_GRP, 1'b1, FLG_H};
   localparam logic [5:0] OP_HALF_CARRY_DROP = {OP_FLAG_GRP, 1'b0, FLG_H};
   localparam logic [1:0] PTR_X = 2'h1;
   localparam logic [1:0] PTR_Y = 2'h2;
   localparam logic [1:0] PTR_Z = 2'h3;
   localparam logic [4:0] PTR_BASE = 5'h18;
   localparam logic [1:0] MODE_PLAIN = 2'h0;
   localparam logic [1:0] MODE_POST_INC = 2'h1;
   localparam logic [1:0] MODE_PRE_DEC = 2'h2;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MEM = 3'b010,
      ST_RD = 3'b100
   } cbfls_state_e;
endpackage : cbfls_pkg

// ===== hw/cbfls_mem_if.sv
// Data memory port between the execution core and its memory
`timescale 1ns/100ps
interface cbfls_mem_if #(
   parameter int AW = 9
);
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic we;
   modport core (output addr, output wdata, output we, input rdata);
   modport mem (input addr, input wdata, input we, output rdata);
endinterface : cbfls_mem_if

// ===== hw/cbfls_dmem.sv
// Synchronous data memory, one cycle read latency
`timescale 1ns/100ps
module cbfls_dmem #(
   parameter int AW = 9
) (
   // Clock
   input wire logic clk,
   // Memory port
   cbfls_mem_if.mem mp
);
   logic [7:0] mem_q [2**AW];
   logic [7:0] rdata_q;

   always_ff @(posedge clk) begin
      if (mp.we) begin
         mem_q[mp.addr] <= mp.wdata;
      end
      rdata_q <= mem_q[mp.addr];
   end

   assign mp.rdata = rdata_q;
endmodule : cbfls_dmem

// ===== hw/cbfls_top.sv
// Bit, flag and load/store execution core with Avalon-MM command port
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
// Operation
// - Rotate left through carry: carry into bit 0, bit 7 out; Z,C,N,V; one cycle
// - Rotate right through carry and arithmetic shift right update Z,C,N,V; one cycle
// - Copy selected source bit into transfer flag only, one cycle
// - Write transfer flag into selected destination bit, flags untouched, one cycle
// - Indexed and dedicated flag set/clear alter only their flag, one cycle
// - Sign flag raise and drop affect only that flag, one cycle
// - Overflow flag raise and drop affect only that flag, one cycle
// - Pointer read loads from pointer address, optional post-increment, two cycles
// - Pre-decrement read: decrement pointer, then load from new address, two cycles
// - Displaced read via second or third pointer, pointer unchanged, two cycles
// - Absolute read loads from instruction address, two cycles, no flags
// - Pointer write stores source, optional post-increment, two cycles, no flags
// - Pre-decrement write: decrement pointer, then store, two cycles
module cbfls_top
   import cbfls_pkg::*;
#(
   parameter int MEM_AW = 9
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);
   cbfls_state_e state_q, state_d;
   logic [31:0] cmd_q, cmd_d, cur, rdata_q, rdata_d;
   logic [15:0] opnd_q, opnd_d, maddr_q, maddr_d;
   logic [7:0] flags_q, flags_d;
   logic [4:0] rsel_q, rsel_d;
   logic [2:0] info_q, info_d;
   logic [7:0] rf_q [RF_WORDS];
   logic [7:0] rf_d [RF_WORDS];
   logic [5:0] f_op;
   logic [4:0] f_rd, f_rr, ptr_lo_idx, ptr_hi_idx;
   logic [2:0] f_bit;
   logic [1:0] f_ptr, f_mode;
   logic [15:0] cur_ptr, ptr_inc, ptr_dec, ea;
   logic [7:0] rd8, rr8, sh_res;
   logic sh_c, c_flag, t_flag, rd_msb, rd_lsb, rr_bit, wait_c;
   logic is_cmd_wr, mem_go, exec1, exec2;

   cbfls_mem_if #(.AW(MEM_AW)) mbus ();

   cbfls_dmem #(.AW(MEM_AW)) u_dmem (
      .clk(CLOCK),
      .mp(mbus)
   );

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         be_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction : be_merge

   function automatic logic mem_op_ok(input logic [5:0] op, input logic [1:0] ptr,
                                      input logic [1:0] mode);
      logic ok;
      ok = 1'b0;
      case (op)
         OP_LDS: ok = 1'b1;
         OP_LDD: ok = (ptr == PTR_Y) || (ptr == PTR_Z);
         OP_LD, OP_ST: ok = (ptr != 2'h0) && (mode != 2'h3);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : mem_op_ok

   function automatic logic [7:0] flag_mask(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction : flag_mask

   // Command decode; first cycle reads the bus, later cycles the latched command
   assign cur = (state_q == ST_IDLE) ? be_merge(cmd_q, AVS_WRITEDATA, AVS_BYTEENABLE) : cmd_q;
   assign f_op = cur[CMD_OP_LSB +: 6];
   assign f_rd = cur[CMD_RD_LSB +: 5];
   assign f_rr = cur[CMD_RR_LSB +: 5];
   assign f_bit = cur[CMD_BIT_LSB +: 3];
   assign f_ptr = cur[CMD_PTR_LSB +: 2];
   assign f_mode = cur[CMD_MODE_LSB +: 2];
   assign rd8 = rf_q[f_rd];
   assign rr8 = rf_q[f_rr];
   assign rd_msb = rd8[7];
   assign rd_lsb = rd8[0];
   assign rr_bit = rr8[f_bit];
   assign c_flag = flags_q[FLG_C];
   assign t_flag = flags_q[FLG_T];
   assign ptr_lo_idx = 5'(PTR_BASE + {2'h0, f_ptr, 1'b0});
   assign ptr_hi_idx = ptr_lo_idx | 5'h01;
   assign cur_ptr = {rf_q[ptr_hi_idx], rf_q[ptr_lo_idx]};
   assign ptr_inc = cur_ptr + 16'h0001;
   assign ptr_dec = cur_ptr - 16'h0001;
   assign is_cmd_wr = AVS_WRITE && (AVS_ADDRESS == REG_CMD);
   assign mem_go = (state_q == ST_IDLE) && is_cmd_wr && mem_op_ok(f_op, f_ptr, f_mode);
   assign exec1 = (state_q == ST_IDLE) && is_cmd_wr && !mem_go;
   assign exec2 = (state_q == ST_MEM) && AVS_WRITE;
   assign AVS_WAITREQUEST = wait_c;
   assign AVS_READDATA = rdata_q;

   // Effective data address
   always_comb begin
      case (f_op)
         OP_LDS: ea = opnd_q;
         OP_LDD: ea = cur_ptr + {{(16-DISP_W){1'b0}}, opnd_q[DISP_W-1:0]};
         default: ea = (f_mode == MODE_PRE_DEC) ? ptr_dec : cur_ptr;
      endcase
   end

   // Rotate and shift unit
   always_comb begin
      sh_res = rd8;
      sh_c = c_flag;
      case (f_op)
         OP_ROL: begin
            sh_res = {rd8[6:0], c_flag};
            sh_c = rd8[7];
         end
         OP_ROR: begin
            sh_res = {c_flag, rd8[7:1]};
            sh_c = rd8[0];
         end
         OP_ASR: begin
            sh_res = {rd8[7], rd8[7:1]};
            sh_c = rd8[0];
         end
         default: begin
         end
      endcase
   end

   // Bus slave, sequencing and execution
   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      opnd_d = opnd_q;
      maddr_d = maddr_q;
      flags_d = flags_q;
      rsel_d = rsel_q;
      info_d = info_q;
      rdata_d = rdata_q;
      rf_d = rf_q;
      wait_c = 1'b0;
      mbus.addr = ea[MEM_AW-1:0];
      mbus.we = 1'b0;
      mbus.wdata = rr8;
      case (state_q)
         ST_IDLE: begin
            if (AVS_READ) begin
               wait_c = 1'b1;
               state_d = ST_RD;
               case (AVS_ADDRESS)
                  REG_CMD: rdata_d = cmd_q;
                  REG_OPND: rdata_d = {16'h0000, opnd_q};
                  REG_FLAGS: rdata_d = {24'h000000, flags_q};
                  REG_INFO: rdata_d = {29'h00000000, info_q};
                  REG_RSEL: rdata_d = {27'h0000000, rsel_q};
                  REG_RDATA: rdata_d = {24'h000000, rf_q[rsel_q]};
                  REG_MADDR: rdata_d = {16'h0000, maddr_q};
                  REG_MDATA: begin
                     mbus.addr = maddr_q[MEM_AW-1:0];
                     state_d = ST_MEM;
                  end
                  default: rdata_d = 32'h00000000;
               endcase
            end else if (AVS_WRITE) begin
               case (AVS_ADDRESS)
                  REG_CMD: begin
                     cmd_d = cur;
                     if (mem_go) begin
                        wait_c = 1'b1;
                        state_d = ST_MEM;
                        mbus.we = (f_op == OP_ST);
                     end else begin
                        info_d = {1'b0, CYC_ONE};
                        case (f_op)
                           OP_ROL, OP_ROR, OP_ASR: begin
                              rf_d[f_rd] = sh_res;
                              flags_d[FLG_C] = sh_c;
                              flags_d[FLG_Z] = (sh_res == 8'h00);
                              flags_d[FLG_N] = sh_res[7];
                              flags_d[FLG_V] = sh_res[7] ^ sh_c;
                           end
                           OP_SWAP: rf_d[f_rd] = {rd8[3:0], rd8[7:4]};
                           OP_FSET: flags_d[f_bit] = 1'b1;
                           OP_FCLR: flags_d[f_bit] = 1'b0;
                           OP_BST: flags_d[FLG_T] = rr_bit;
                           OP_BLD: rf_d[f_rd][f_bit] = t_flag;
                           OP_MOV: rf_d[f_rd] = rr8;
                           OP_REG_PAIR_COPY: begin
                              rf_d[{f_rd[4:1], 1'b0}] = rf_q[{f_rr[4:1], 1'b0}];
                              rf_d[{f_rd[4:1], 1'b1}] = rf_q[{f_rr[4:1], 1'b1}];
                           end
                           OP_LDI: rf_d[f_rd] = opnd_q[7:0];
                           default: begin
                              if (f_op[5:4] == OP_FLAG_GRP) begin
                                 flags_d[f_op[2:0]] = f_op[3];
                              end else begin
                                 info_d = {1'b1, CYC_ONE};
                              end
                           end
                        endcase
                     end
                  end
                  REG_OPND: opnd_d = 16'(be_merge({16'h0000, opnd_q}, AVS_WRITEDATA,
                                                  AVS_BYTEENABLE));
                  REG_FLAGS: flags_d = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : flags_q;
                  REG_RSEL: rsel_d = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[4:0] : rsel_q;
                  REG_RDATA: rf_d[rsel_q] = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : rf_q[rsel_q];
                  REG_MADDR: maddr_d = 16'(be_merge({16'h0000, maddr_q}, AVS_WRITEDATA,
                                                    AVS_BYTEENABLE));
                  REG_MDATA: begin
                     mbus.addr = maddr_q[MEM_AW-1:0];
                     mbus.wdata = AVS_WRITEDATA[7:0];
                     mbus.we = AVS_BYTEENABLE[0];
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_MEM: begin
            if (AVS_READ) begin
               wait_c = 1'b1;
               rdata_d = {24'h000000, mbus.rdata};
               state_d = ST_RD;
            end else begin
               state_d = ST_IDLE;
               info_d = {1'b0, CYC_TWO};
               if ((f_op == OP_LD) || (f_op == OP_ST)) begin
                  if (f_mode == MODE_POST_INC) begin
                     rf_d[ptr_lo_idx] = ptr_inc[7:0];
                     rf_d[ptr_hi_idx] = ptr_inc[15:8];
                  end else if (f_mode == MODE_PRE_DEC) begin
                     rf_d[ptr_lo_idx] = ptr_dec[7:0];
                     rf_d[ptr_hi_idx] = ptr_dec[15:8];
                  end
               end
               if (f_op != OP_ST) begin
                  rf_d[f_rd] = mbus.rdata;
               end
            end
         end
         ST_RD: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= ST_IDLE;
         cmd_q <= '0;
         opnd_q <= '0;
         maddr_q <= '0;
         flags_q <= FLAGS_RST;
         rsel_q <= '0;
         info_q <= '0;
         rdata_q <= '0;
         for (int i = 0; i < RF_WORDS; i++) begin
            rf_q[i] <= '0;
         end
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         opnd_q <= opnd_d;
         maddr_q <= maddr_d;
         flags_q <= flags_d;
         rsel_q <= rsel_d;
         info_q <= info_d;
         rdata_q <= rdata_d;
         rf_q <= rf_d;
      end
   end

   // Checks
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   property p_rol;
      exec1 && f_op == OP_ROL |=> c_flag == $past(rd_msb)
         && rf_q[$past(f_rd)][0] == $past(c_flag) && flags_q[FLG_Z] == (rf_q[$past(f_rd)] == 8'h00);
   endproperty
   a_rol: assert property (p_rol) else $error("rotate left wrong");
   property p_ror;
      exec1 && f_op == OP_ROR |=> c_flag == $past(rd_lsb) && rf_q[$past(f_rd)][7] == $past(c_flag)
         && flags_q[FLG_V] == (flags_q[FLG_N] ^ c_flag);
   endproperty
   a_ror: assert property (p_ror) else $error("rotate right wrong");
   property p_asr;
      exec1 && f_op == OP_ASR |=> rf_q[$past(f_rd)][7] == $past(rd_msb) && c_flag == $past(rd_lsb);
   endproperty
   a_asr: assert property (p_asr) else $error("shift right wrong");
   property p_bst;
      exec1 && f_op == OP_BST |=> t_flag == $past(rr_bit)
         && (flags_q | flag_mask(FLG_T)) == ($past(flags_q) | flag_mask(FLG_T));
   endproperty
   a_bst: assert property (p_bst) else $error("bit to transfer flag wrong");
   property p_bld;
      exec1 && f_op == OP_BLD |=> flags_q == $past(flags_q)
         && rf_q[$past(f_rd)][$past(f_bit)] == $past(t_flag);
   endproperty
   a_bld: assert property (p_bld) else $error("transfer flag to bit wrong");
   property p_fset;
      exec1 && f_op == OP_FSET |=> flags_q == ($past(flags_q) | flag_mask($past(f_bit)));
   endproperty
   a_fset: assert property (p_fset) else $error("indexed flag set wrong");
   property p_sign;
      exec1 && f_op == OP_SIGN_FLAG_RAISE |=> flags_q == ($past(flags_q) | flag_mask(FLG_S));
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag raise wrong");
   property p_ovf;
      exec1 && f_op == OP_OVERFLOW_FLAG_DROP |=> flags_q == ($past(flags_q) & ~flag_mask(FLG_V));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag drop wrong");
   property p_ld_two;
      mem_go && f_op == OP_LD |-> AVS_WAITREQUEST ##1 (!AVS_WAITREQUEST && flags_q == $past(flags_q));
   endproperty
   a_ld_two: assert property (p_ld_two) else $error("pointer read not two cycles");
   property p_postinc;
      exec2 && f_op == OP_LD && f_mode == MODE_POST_INC && f_rd[4:1] != ptr_lo_idx[4:1]
         |=> {rf_q[$past(ptr_hi_idx)], rf_q[$past(ptr_lo_idx)]} == $past(ptr_inc);
   endproperty
   a_postinc: assert property (p_postinc) else $error("post increment wrong");
   property p_predec;
      mem_go && (f_op == OP_LD || f_op == OP_ST) && f_mode == MODE_PRE_DEC
         |-> mbus.addr == ptr_dec[MEM_AW-1:0];
   endproperty
   a_predec: assert property (p_predec) else $error("pre decrement address wrong");
   property p_ldd;
      exec2 && f_op == OP_LDD && f_rd[4:1] != ptr_lo_idx[4:1]
         |=> {rf_q[$past(ptr_hi_idx)], rf_q[$past(ptr_lo_idx)]} == $past(cur_ptr);
   endproperty
   a_ldd: assert property (p_ldd) else $error("displaced read moved pointer");
   property p_lds;
      exec2 && f_op == OP_LDS |=> rf_q[$past(f_rd)] == $past(mbus.rdata);
   endproperty
   a_lds: assert property (p_lds) else $error("absolute read wrong");
   property p_st;
      mem_go && f_op == OP_ST |-> mbus.we && mbus.wdata == rr8 ##1 (!mbus.we && !AVS_WAITREQUEST);
   endproperty
   a_st: assert property (p_st) else $error("pointer write wrong");
endmodule : cbfls_top

// ===== verif/cbfls_mem_model.sv
// Behavioural image of the data memory that the core reads and writes
`timescale 1ns/100ps
module cbfls_mem_model #(
   parameter int AW = 9
);
   logic [7:0] mem [2**AW];
endmodule : cbfls_mem_model

// ===== verif/tb.sv
// Self-checking bench for the bit, flag and load/store execution core
`timescale 1ns/100ps
module tb;
   import cbfls_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] adr = '0;
   logic rdq = 1'b0;
   logic wrq = 1'b0;
   logic [31:0] wd = '0;
   logic [31:0] rdat;
   logic wq;
   int err_count = 0;
   int check_count = 0;
   int seed = 32'haffeea94;
   logic [7:0] expq[$];
   string nq[$];
   logic [7:0] rf[32] = '{default: 8'h00};
   logic [7:0] fm = 8'h00;
   logic [15:0] opnd = '0;
   logic [5:0] sops[4] = '{OP_ROL, OP_ROR, OP_ASR, OP_SWAP};
   logic [7:0] bv[4] = '{8'h00, 8'h80, 8'h01, 8'hFF};
   cbfls_mem_model cbfls_mem_model_i ();
   cbfls_top cbfls_top_i (.CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(adr), .AVS_READ(rdq),
      .AVS_WRITE(wrq), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq));
   initial forever #12.5 clock = ~clock;
   task automatic finish_test();
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   task automatic cmp_rd(input logic [7:0] e, input string s);
      check_count++;
      if (rdat !== {24'h000000, e}) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", s, {24'h000000, e}, rdat);
      end
   endtask : cmp_rd
   // Read data is taken in the accepting cycle
   always @(negedge clock) begin
      if (rdq && wq === 1'b0 && expq.size() > 0) cmp_rd(expq.pop_front(), nq.pop_front());
   end
   // Avalon master: hold the request until waitrequest is seen low
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      adr <= a;
      wd <= d;
      wrq <= w;
      rdq <= !w;
      do begin
         @(negedge clock);
         n++;
      end while (wq !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("ERROR waitrequest expected 0 seen 1");
      end
      @(posedge clock);
      wrq <= 1'b0;
      rdq <= 1'b0;
   endtask : bus
   task automatic chk(input logic [4:0] a, input logic [7:0] e, input string s);
      expq.push_back(e);
      nq.push_back(s);
      bus(a, 1'b0, '0);
   endtask : chk
   task automatic wreg(input int i, input logic [7:0] v);
      bus(REG_RSEL, 1'b1, 32'(i));
      bus(REG_RDATA, 1'b1, {24'h0, v});
      rf[i] = v;
   endtask : wreg
   task automatic creg(input int i);
      bus(REG_RSEL, 1'b1, 32'(i));
      chk(REG_RDATA, rf[i], "register");
   endtask : creg
   task automatic setp(input int p, input logic [15:0] v);
      wreg(PTR_BASE + 2 * p, v[7:0]);
      wreg(PTR_BASE + 2 * p + 1, v[15:8]);
   endtask : setp
   task automatic cptr(input int p);
      creg(PTR_BASE + 2 * p);
      creg(PTR_BASE + 2 * p + 1);
   endtask : cptr
   // Issue one command, update the reference state and check the cycle count
   task automatic ex(input logic [5:0] op, input int d, input int s, input int b, input int p,
      input int md);
      logic [7:0] v, r;
      logic c, mem, bad;
      logic [15:0] pv, ea;
      int lo;
      bus(REG_CMD, 1'b1, {1'b0, 2'(md), 2'(p), 3'(b), 3'h0, 5'(s), 3'h0, 5'(d), 2'h0, op});
      lo = PTR_BASE + 2 * p;
      v = rf[d];
      pv = {rf[lo + 1], rf[lo]};
      mem = op inside {OP_LD, OP_LDD, OP_LDS, OP_ST};
      bad = (op == OP_LDD && p < 2) || (op inside {OP_LD, OP_ST} && (p == 0 || md == 3))
         || op == 6'h00 || op > 6'h1F;
      if (md == 2) pv = pv - 16'h1;
      ea = op == OP_LDD ? pv + 16'(opnd[5:0]) : (op == OP_LDS ? opnd : pv);
      if (!bad) begin
         case (op)
            OP_ROL, OP_ROR, OP_ASR: begin
               r = op == OP_ROL ? {v[6:0], fm[FLG_C]} : {op == OP_ROR ? fm[FLG_C] : v[7], v[7:1]};
               c = op == OP_ROL ? v[7] : v[0];
               rf[d] = r;
               fm[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
            end
            OP_SWAP: rf[d] = {v[3:0], v[7:4]};
            OP_FSET: fm[b] = 1'b1;
            OP_FCLR: fm[b] = 1'b0;
            OP_BST: fm[FLG_T] = rf[s][b];
            OP_BLD: rf[d][b] = fm[FLG_T];
            OP_MOV: rf[d] = rf[s];
            OP_REG_PAIR_COPY: begin
               rf[d & 30] = rf[s & 30];
               rf[d | 1] = rf[s | 1];
            end
            OP_LDI: rf[d] = opnd[7:0];
            OP_ST: cbfls_mem_model_i.mem[ea[8:0]] = rf[s];
            default: if (op[5:4] == OP_FLAG_GRP) fm[op[2:0]] = op[3];
         endcase
         if (mem && md != 0) begin
            pv = md == 1 ? pv + 16'h1 : pv;
            rf[lo] = pv[7:0];
            rf[lo + 1] = pv[15:8];
         end
         if (mem && op != OP_ST) rf[d] = cbfls_mem_model_i.mem[ea[8:0]];
      end
      chk(REG_INFO, bad ? 8'h05 : (mem ? 8'h02 : 8'h01), "info");
   endtask : ex
   initial begin
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      chk(REG_FLAGS, 8'h00, "flags");
      creg(PTR_BASE);
      for (int i = 0; i < 8; i++) begin
         fm = 8'($random(seed));
         bus(REG_FLAGS, 1'b1, 32'(fm));
         for (int j = 0; j < 4; j++) begin
            ex(j < 2 ? (j ? OP_FCLR : OP_FSET) : {OP_FLAG_GRP, j == 2, 3'(i)}, 0, 0, i, 3, 0);
            chk(REG_FLAGS, fm, "flags");
         end
      end
      for (int k = 0; k < 32; k++) begin
         fm = 8'($random(seed));
         bus(REG_FLAGS, 1'b1, 32'(fm));
         wreg(3, k < 16 ? bv[k / 4] : 8'($random(seed)));
         ex(sops[k % 4], 3, 0, 0, 3, 0);
         creg(3);
         chk(REG_FLAGS, fm, "flags");
      end
      for (int b = 0; b < 8; b++) begin
         wreg(7, 8'($random(seed)));
         wreg(9, 8'($random(seed)));
         ex(OP_BST, 0, 7, b, 3, 0);
         ex(OP_BLD, 9, 0, 7 - b, 3, 0);
         creg(9);
         chk(REG_FLAGS, fm, "flags");
      end
      wreg(2, 8'($random(seed)));
      wreg(3, 8'($random(seed)));
      opnd = 16'($random(seed));
      bus(REG_OPND, 1'b1, {16'h0, opnd});
      ex(OP_MOV, 10, 3, 0, 3, 0);
      ex(OP_REG_PAIR_COPY, 12, 2, 0, 3, 0);
      ex(OP_LDI, 17, 0, 0, 3, 0);
      for (int i = 10; i < 18; i++) creg(i);
      for (int a = 64; a < 96; a++) begin
         bus(REG_MADDR, 1'b1, 32'(a));
         cbfls_mem_model_i.mem[a] = 8'($random(seed));
         bus(REG_MDATA, 1'b1, {24'h0, cbfls_mem_model_i.mem[a]});
      end
      for (int i = 0; i < 9; i++) begin
         setp(i / 3 + 1, 16'h0048);
         ex(OP_LD, 5, 0, 0, i / 3 + 1, i % 3);
         creg(5);
         cptr(i / 3 + 1);
         wreg(4, 8'($random(seed)));
         setp(i / 3 + 1, 16'h0050);
         ex(OP_ST, 0, 4, 0, i / 3 + 1, i % 3);
         cptr(i / 3 + 1);
         bus(REG_MADDR, 1'b1, i % 3 == 2 ? 32'h4F : 32'h50);
         chk(REG_MDATA, rf[4], "memory");
      end
      for (int p = 2; p < 4; p++) begin
         opnd = 16'($random(seed)) & 16'h000F;
         bus(REG_OPND, 1'b1, {16'h0, opnd});
         setp(p, 16'h0044);
         ex(OP_LDD, 6, 0, 0, p, 0);
         creg(6);
         cptr(p);
      end
      opnd = 16'h005A;
      bus(REG_OPND, 1'b1, {16'h0, opnd});
      ex(OP_LDS, 8, 0, 0, 3, 0);
      creg(8);
      ex(OP_LDD, 8, 0, 0, 1, 0);
      ex(OP_LD, 8, 0, 0, 0, 0);
      ex(OP_ST, 0, 4, 0, 2, 3);
      ex(6'h3F, 8, 0, 0, 3, 0);
      creg(8);
      cptr(2);
      chk(REG_FLAGS, fm, "flags");
      finish_test();
   end
   initial begin
      repeat (30000) @(posedge clock);
      err_count++;
      $display("ERROR watchdog expected finish seen hang");
      finish_test();
   end
endmodule : tb
